// ---- src/fspg_params.svh ----
// Purpose: constants for the flash self programming mode guard
// Assumes: 32-bit Avalon-MM word registers, word addresses
// Notes:   offsets are word aligned
`ifndef FSPG_PARAMS_SVH
`define FSPG_PARAMS_SVH
`define FSPG_OFS_CMD      4'h0
`define FSPG_OFS_STATUS   4'h1
`define FSPG_OFS_PROTCMD  4'h2
`define FSPG_OFS_MODECTL  4'h3
`define FSPG_OFS_PSEL     4'h4
`define FSPG_OFS_BLKREQ   4'h5
`define FSPG_OFS_CONFIG   4'h6
`define FSPG_KEY          8'ha5
`define FSPG_MODE_SELF    8'h01
`define FSPG_MODE_NORM    8'h00
`define FSPG_PSEL_RST     5'h1f
`define FSPG_ERR_BIT      0
`define FSPG_DENY_BIT     1
`endif

// ---- src/fspg_pkg.sv ----
// Purpose: types for the flash self programming mode guard
// Assumes: nothing
// Notes:   states of the protected write sequence
package fspg_pkg;
	typedef enum logic [1:0] {
		FSPG_IDLE,
		FSPG_KEYED,
		FSPG_FIRST,
		FSPG_SECOND
	} fspg_seq_t;
endpackage

// ---- src/fspg_protect_decode.sv ----
// Purpose: decode the protect select code into a per-block protect mask
// Assumes: select code held steady by the caller
// Notes:   prohibited codes protect nothing, flagged as illegal
`timescale 1ns/100ps
`include "fspg_params.svh"
module fspg_protect_decode (
	input  wire logic [4:0]  sel,
	input  wire logic        big_array,
	output logic      [15:0] prot_mask,
	output logic             illegal
);
	wire logic [3:0] top_blk;
	wire logic       code_ok;
	// sixteen blocks: code 01kkk protects 0..15-2k; eight: 011kk protects 0..7-2kk
	assign code_ok = big_array ? (sel[4:3] == 2'b01)
	                           : (sel[4:2] == 3'b011);
	assign top_blk = big_array ? 4'(4'hf - {sel[2:0], 1'b0})
	                           : 4'(4'h7 - {1'b0, sel[1:0], 1'b0});
	assign illegal = !code_ok && (sel != `FSPG_PSEL_RST);
	genvar i;
	generate
		for (i = 0; i < 16; i++) begin : g_blk
			assign prot_mask[i] = code_ok && (4'(i) <= top_blk);
		end
	endgenerate
endmodule

// ---- src/fspg_guard.sv ----
// Purpose: self programming mode guard with protected mode-change sequence
// Assumes: Avalon-MM slave, one wait state per access, synchronous active-high reset
// Notes:   erase/write execution lives elsewhere; this block grants or denies it
`timescale 1ns/100ps
`include "fspg_params.svh"
module fspg_guard (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	output logic             self_prog_mode,
	output logic      [15:0] prot_mask,
	output logic             blk_grant,
	output logic             blk_deny
);
	fspg_pkg::fspg_seq_t seq_reg, seq_next;
	logic [7:0]  mode_reg, mode_next;
	logic [7:0]  pend_reg, pend_next;
	logic [7:0]  cmd_reg;
	logic [4:0]  psel_reg;
	logic        big_reg;
	logic        err_reg, err_next;
	logic        deny_flag_reg, deny_flag_next;
	logic [31:0] rdata_next;
	logic [15:0] prot_mask_next;
	logic        wait_reg;

	wire logic        acc;
	wire logic        wr;
	wire logic [7:0]  wbyte;
	wire logic        wr_key;
	wire logic        wr_mode;
	wire logic        wr_status;
	wire logic        wr_blk;
	wire logic [15:0] dec_mask;
	wire logic        dec_illegal;
	wire logic        blk_hit;
	wire logic        seq_ok;
	wire logic        seq_bad;
	wire logic        self_next;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
		hit = (a == ofs);
	endfunction

	fspg_protect_decode u_dec (
		.sel       (psel_reg),
		.big_array (big_reg),
		.prot_mask (dec_mask),
		.illegal   (dec_illegal)
	);

	// one wait cycle per access so every answer comes from a flop
	// read data launches with waitrequest low, so both stand at the taking edge
	assign acc       = (avs_read || avs_write) && !wait_reg;
	assign wr        = avs_write && wait_reg;
	assign wbyte     = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;
	assign wr_key    = wr && hit(avs_address, `FSPG_OFS_PROTCMD);
	assign wr_mode   = wr && hit(avs_address, `FSPG_OFS_MODECTL);
	assign wr_status = wr && hit(avs_address, `FSPG_OFS_STATUS);
	assign wr_blk    = wr && hit(avs_address, `FSPG_OFS_BLKREQ);
	// any other register write inside the sequence breaks it
	assign seq_bad   = wr && !wr_mode && (seq_reg != fspg_pkg::FSPG_IDLE);
	assign seq_ok    = wr_mode && (seq_reg == fspg_pkg::FSPG_SECOND)
	                   && (wbyte == pend_reg)
	                   && ((pend_reg == `FSPG_MODE_SELF) || (pend_reg == `FSPG_MODE_NORM));
	assign blk_hit   = dec_mask[wbyte[3:0]] && self_prog_mode;

	always_comb begin
		seq_next  = seq_reg;
		mode_next = mode_reg;
		pend_next = pend_reg;
		err_next  = err_reg;
		if (wr_key) begin
			seq_next = fspg_pkg::FSPG_KEYED;
		end else if (seq_bad) begin
			seq_next = fspg_pkg::FSPG_IDLE;
			err_next = 1'b1;
		end else if (wr_mode) begin
			// mode control holds its value until the third write
			case (seq_reg)
				fspg_pkg::FSPG_KEYED: begin
					pend_next = wbyte;
					seq_next  = fspg_pkg::FSPG_FIRST;
				end
				fspg_pkg::FSPG_FIRST: begin
					seq_next = (wbyte == ~pend_reg) ? fspg_pkg::FSPG_SECOND
					                                : fspg_pkg::FSPG_IDLE;
					err_next = err_reg || (wbyte != ~pend_reg);
				end
				fspg_pkg::FSPG_SECOND: begin
					seq_next = fspg_pkg::FSPG_IDLE;
					if (seq_ok) begin
						mode_next = wbyte;
					end else begin
						err_next = 1'b1;
					end
				end
				default: begin
					err_next = 1'b1;
				end
			endcase
		end
		// set wins over clear: only a clear with no error event this cycle drops it
		if (wr_status && !wbyte[`FSPG_ERR_BIT] && !seq_bad) begin
			err_next = 1'b0;
		end
	end

	always_comb begin
		deny_flag_next = deny_flag_reg;
		if (wr_blk && blk_hit) begin
			deny_flag_next = 1'b1;
		end else if (wr_status && !wbyte[`FSPG_DENY_BIT]) begin
			deny_flag_next = 1'b0;
		end
	end

	always_comb begin
		rdata_next = 32'h0000_0000;
		case (avs_address)
			`FSPG_OFS_CMD:     rdata_next = {24'h000000, cmd_reg};
			`FSPG_OFS_STATUS:  rdata_next = {30'h0, deny_flag_reg, err_reg};
			`FSPG_OFS_MODECTL: rdata_next = {24'h000000, mode_reg};
			`FSPG_OFS_PSEL:    rdata_next = {27'h0, psel_reg};
			`FSPG_OFS_CONFIG:  rdata_next = {30'h0, dec_illegal, big_reg};
			default:           rdata_next = 32'h0000_0000;
		endcase
	end

	// mask follows the next mode so it never outlives self programming by a cycle
	assign self_next      = (mode_next == `FSPG_MODE_SELF);
	assign prot_mask_next = self_next ? dec_mask : 16'h0000;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			seq_reg  <= fspg_pkg::FSPG_IDLE;
			mode_reg <= `FSPG_MODE_NORM;
			pend_reg <= 8'h00;
			err_reg  <= 1'b0;
			deny_flag_reg <= 1'b0;
		end else begin
			seq_reg  <= seq_next;
			mode_reg <= mode_next;
			pend_reg <= pend_next;
			err_reg  <= err_next;
			deny_flag_reg <= deny_flag_next;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cmd_reg  <= 8'h00;
			psel_reg <= `FSPG_PSEL_RST;
			big_reg  <= 1'b1;
		end else begin
			if (wr && hit(avs_address, `FSPG_OFS_CMD)) begin
				cmd_reg <= wbyte;
			end
			if (wr && hit(avs_address, `FSPG_OFS_PSEL)) begin
				psel_reg <= wbyte[4:0];
			end
			if (wr && hit(avs_address, `FSPG_OFS_CONFIG)) begin
				big_reg <= wbyte[0];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wait_reg        <= 1'b0;
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
			self_prog_mode  <= 1'b0;
			prot_mask       <= 16'h0000;
			blk_grant       <= 1'b0;
			blk_deny        <= 1'b0;
		end else begin
			wait_reg        <= acc;
			avs_waitrequest <= !acc;
			avs_readdata    <= (acc && avs_read) ? rdata_next : 32'h0000_0000;
			self_prog_mode  <= self_next;
			prot_mask       <= prot_mask_next;
			blk_grant       <= wr_blk && !blk_hit;
			blk_deny        <= wr_blk && blk_hit;
		end
	end
endmodule

// ---- bench/fspg_guard_asserts.sv ----
// Purpose: port checks for fspg_guard
// Assumes: a write is taken where waitrequest is low
// Notes:   mode lags its write by one edge; checks allow up to two
`timescale 1ns/100ps
module fspg_guard_asserts (
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic [3:0]  avs_address,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic        avs_waitrequest,
	input wire logic        self_prog_mode,
	input wire logic [15:0] prot_mask,
	input wire logic        blk_grant,
	input wire logic        blk_deny
);
	wire logic [7:0] wd  = avs_writedata[7:0];
	wire logic       tk  = avs_write && !avs_waitrequest;
	wire logic       mw  = tk && avs_address == 4'h3;
	wire logic       bw  = tk && avs_address == 4'h5;
	wire logic       m1  = mw && wd == 8'h01;
	wire logic       m0  = mw && wd == 8'h00;
	wire logic       inv = mw && wd[7:1] == 7'h7f;
	wire logic       bad = mw && wd[7:1] != 7'h7f && wd[7:1] != 7'h00;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	chk_mask_off: assert property (!self_prog_mode |-> prot_mask == 16'h0000)
		else $error("mask live in normal mode");
	chk_deny_prot: assert property (blk_deny |-> self_prog_mode && prot_mask != 16'h0000)
		else $error("deny without protection");
	chk_grant_deny: assert property (!(blk_grant && blk_deny))
		else $error("grant and deny together");
	chk_req_pulse: assert property (blk_grant || blk_deny |-> $past(bw) || $past(bw, 2))
		else $error("pulse without request");
	chk_mode_entry: assert property ($rose(self_prog_mode) |-> $past(m1) || $past(m1, 2))
		else $error("mode rose without 01 write");
	chk_mode_exit: assert property ($fell(self_prog_mode) |-> $past(m0) || $past(m0, 2))
		else $error("mode fell without 00 write");
	chk_inv_hold: assert property (inv |=> $stable(self_prog_mode) [*2])
		else $error("inverted write moved mode");
	chk_bad_hold: assert property (bad |=> $stable(self_prog_mode) [*2])
		else $error("bad write moved mode");
	cover property ($rose(self_prog_mode));
	cover property ($fell(self_prog_mode));
	cover property (blk_deny);
endmodule
bind fspg_guard fspg_guard_asserts i_chk (.clk_sys, .rst, .avs_address, .avs_write,
	.avs_writedata, .avs_waitrequest, .self_prog_mode, .prot_mask, .blk_grant, .blk_deny);

// ---- bench/fspg_guard_tb.sv ----
// Purpose: self-checking bench for fspg_guard
// Assumes: every access is answered
// Notes:   protect table runs in self mode
`timescale 1ns/100ps
module fspg_guard_tb;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, q;
	logic        avs_waitrequest, self_prog_mode, blk_grant, blk_deny;
	logic [15:0] prot_mask;
	int          mismatches = 0, checks_done = 0, gs = 0, ds = 0;
	logic [21:0] rows [16] = '{22'h28ffff, 22'h293fff, 22'h2a0fff, 22'h2b03ff, 22'h2c00ff,
		22'h2d003f, 22'h2e000f, 22'h2f0003, 22'h3f0000, 22'h200000, 22'h0c00ff, 22'h0d003f,
		22'h0e000f, 22'h0f0003, 22'h1f0000, 22'h080000};
	fspg_guard i_dut (.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable(4'h1), .avs_readdata, .avs_waitrequest, .self_prog_mode,
		.prot_mask, .blk_grant, .blk_deny);
	always #25 clk_sys = ~clk_sys;
	// pulses counted by nba so readers at the edge see settled totals
	always @(posedge clk_sys) begin
		gs <= gs + (blk_grant === 1'b1);
		ds <= ds + (blk_deny === 1'b1);
	end
	task chk(input logic [31:0] g, e);
		begin
			checks_done++;
			if (g !== e) begin
				mismatches++;
				$display("ERROR at %0t got %h exp %h", $time, g, e);
			end
		end
	endtask
	task acc(input logic [3:0] a, input logic w, input logic [7:0] d);
		begin
			avs_address <= a;
			avs_write <= w;
			avs_read <= !w;
			avs_writedata <= {24'h000000, d};
			// only the watchdog ends a wait that never gets its answer
			do begin
				@(posedge clk_sys);
			end while (avs_waitrequest !== 1'b0);
			q = avs_readdata;
			avs_write <= 1'b0;
			avs_read <= 1'b0;
			@(posedge clk_sys);
		end
	endtask
	task rd(input logic [3:0] a, input logic [31:0] e);
		begin
			acc(a, 1'b0, 8'h00);
			chk(q, e);
		end
	endtask
	// ab slips a foreign register write into the sequence
	task seq(input logic [7:0] v, x, input logic ab);
		begin
			acc(4'h0, 1'b1, 8'h00);
			acc(4'h1, 1'b1, 8'h00);
			acc(4'h2, 1'b1, 8'ha5);
			acc(4'h3, 1'b1, v);
			rd(4'h3, {24'h000000, v ^ 8'h01});
			if (ab) acc(4'h0, 1'b1, 8'h00);
			acc(4'h3, 1'b1, x);
			acc(4'h3, 1'b1, v);
			repeat (3) @(posedge clk_sys);
		end
	endtask
	task results;
		begin
			$display("checks %0d mismatches %0d", checks_done, mismatches);
			if (mismatches == 0 && checks_done > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	initial begin
		#150000;
		mismatches++;
		results;
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk(avs_waitrequest, 32'h1);
		rd(4'h4, 32'h1f);
		rd(4'h6, 32'h1);
		acc(4'h4, 1'b1, 8'h08);
		acc(4'h5, 1'b1, 8'h00);
		seq(8'h01, 8'hfe, 1'b0);
		chk(self_prog_mode, 32'h1);
		chk(gs, 32'h1);
		rd(4'h1, 32'h0);
		foreach (rows[i]) begin
			acc(4'h6, 1'b1, {7'h00, rows[i][21]});
			acc(4'h4, 1'b1, {3'h0, rows[i][20:16]});
			repeat (2) @(posedge clk_sys);
			chk(prot_mask, rows[i][15:0]);
		end
		acc(4'h6, 1'b1, 8'h01);
		acc(4'h4, 1'b1, 8'h0c);
		acc(4'h5, 1'b1, 8'h07);
		acc(4'h5, 1'b1, 8'h08);
		repeat (3) @(posedge clk_sys);
		chk(ds, 32'h1);
		chk(gs, 32'h2);
		rd(4'h1, 32'h2);
		seq(8'h00, 8'hff, 1'b1);
		chk(self_prog_mode, 32'h1);
		rd(4'h1, 32'h1);
		seq(8'h00, 8'hfd, 1'b0);
		chk(self_prog_mode, 32'h1);
		rd(4'h1, 32'h1);
		seq(8'h00, 8'hff, 1'b0);
		chk(self_prog_mode, 32'h0);
		chk(prot_mask, 32'h0);
		rd(4'h1, 32'h0);
		// reset in mid-run while in self programming mode
		seq(8'h01, 8'hfe, 1'b0);
		chk(self_prog_mode, 32'h1);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		chk(self_prog_mode, 32'h0);
		chk(prot_mask, 32'h0);
		rd(4'h4, 32'h1f);
		results;
	end
endmodule
